/* src/rwgda_ram_guard.sv */
/*
 * RAM front end: AHB-Lite slave onto an on-chip RAM array, a fixed
 * priority arbiter for the peripheral DMA channels, a 32-byte block write
 * guard with DMA fault capture, and a small register file with interrupt.
 * Assumes AHB masters, DMA channels and the register port all run on
 * CORE_CLK_I; HIGH_CLK_MODE_I comes from clock control on the same clock.
 */
//
// Functional notes
// - 12 kB RAM decoded at 0x20000000
// - byte, half-word, word accesses from any master
// - 32-bit, zero waits, two in high mode
// - six DMA channels: MAC and serial
// - receive and transmit may request together
// - DMA uses own RAM path, not AHB
// - fixed priority DMA, processor still served
// - RAM split into 32-byte guard blocks
// - user write to protected block: bus error
// - privileged writes and all reads pass
// - register bitmap, set bit protects block
// - config bit applies map to DMA writes
// - protected DMA write raises interrupt
// - capture fault address and channel id
// - only receive channels can fault
// - registers at 0x40006000, word-aligned access
`timescale 1ns/1ps
module rwgda_ram_guard #(
   parameter int RAM_BYTES = rwgda_pkg::RAM_BYTES,
   parameter int NUM_DMA   = 6
) (
   input  wire logic                                    CORE_CLK_I,
   input  wire logic                                    RST_N_I,
   input  wire logic                                    HSEL_I,
   input  wire logic [31:0]                             HADDR_I,
   input  wire logic [1:0]                              HTRANS_I,
   input  wire logic                                    HWRITE_I,
   input  wire logic [2:0]                              HSIZE_I,
   input  wire logic [3:0]                              HPROT_I,
   input  wire logic [31:0]                             HWDATA_I,
   input  wire logic                                    HREADY_I,
   output logic                                         HREADYOUT_O,
   output logic                                         HRESP_O,
   output logic [31:0]                                  HRDATA_O,
   input  wire logic                                    HIGH_CLK_MODE_I,
   input  wire logic [NUM_DMA-1:0]                      DMA_REQ_I,
   input  wire logic [NUM_DMA*rwgda_pkg::BYTE_ADDR_W-1:0] DMA_ADDR_I,
   input  wire logic [NUM_DMA*32-1:0]                   DMA_WDATA_I,
   output logic [NUM_DMA-1:0]                           DMA_GNT_O,
   output logic [NUM_DMA-1:0]                           DMA_RVALID_O,
   output logic [31:0]                                  DMA_RDATA_O,
   input  wire logic [31:0]                             REG_ADDR_I,
   input  wire logic [31:0]                             REG_WDATA_I,
   input  wire logic                                    REG_WR_I,
   input  wire logic                                    REG_RD_I,
   output logic [31:0]                                  REG_RDATA_O,
   output logic                                         IRQ_O
);

   // ------------------------------------------------------------------
   // sizes and elaboration checks
   // ------------------------------------------------------------------
   localparam int AW        = rwgda_pkg::BYTE_ADDR_W;
   localparam int RAM_WORDS = RAM_BYTES / 4;
   localparam int MAP_BITS  = RAM_BYTES / rwgda_pkg::BLOCK_BYTES;
   localparam int MAP_REGS  = MAP_BITS / 32;
   localparam int ID_W      = 3;

   if (RAM_BYTES % 1024 != 0 || RAM_BYTES < 1024 ||
       RAM_BYTES > (1 << AW)) begin : g_bad_ram
      $error("RAM_BYTES must be a multiple of 1024 up to 16384");
   end
   if (NUM_DMA < 1 || NUM_DMA > 8) begin : g_bad_dma
      $error("NUM_DMA must lie between 1 and 8");
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // byte lane select
   function automatic logic [3:0] lane_mask(input logic [2:0] size,
                                            input logic [1:0] ofs);
      logic [3:0] m;
      m = 4'hF;
      case (size)
         3'h0: m = 4'h1 << ofs;
         3'h1: m = ofs[1] ? 4'hC : 4'h3;
         default: m = 4'hF;
      endcase
      return m;
   endfunction

   function automatic logic in_ram(input logic [AW-1:0] byte_addr);
      return 32'(byte_addr) < 32'(RAM_BYTES);
   endfunction

   function automatic logic blk_prot(input logic [MAP_BITS-1:0] map,
                                     input logic [AW-1:0]       byte_addr);
      logic [AW-6:0] blk;
      blk = byte_addr[AW-1:5];
      return in_ram(byte_addr) && map[blk];
   endfunction

   // ------------------------------------------------------------------
   // storage and register state
   // ------------------------------------------------------------------
   // RAM array
   logic [31:0]                   mem [RAM_WORDS];
   logic [MAP_BITS-1:0]           prot_map_reg;
   logic                          dma_prot_en_reg;
   logic [rwgda_pkg::STAT_W-1:0]  status_reg;
   logic [rwgda_pkg::STAT_W-1:0]  mask_reg;
   logic [AW-1:0]                 fault_addr_reg;
   logic [ID_W-1:0]               fault_id_reg;
   logic [31:0]                   reg_rdata_reg;

   // ------------------------------------------------------------------
   // AHB address and data phase
   // ------------------------------------------------------------------
   rwgda_pkg::rwgda_ahb_state_type ahb_state_reg;
   rwgda_pkg::rwgda_ahb_state_type ahb_state_next;
   logic                          dp_write_reg;
   logic [AW-1:0]                 dp_addr_reg;
   logic [3:0]                    dp_mask_reg;
   logic [1:0]                    wait_cnt_reg;
   logic                          ahb_starved_reg;
   logic                          accept;
   logic                          addr_hit;
   logic                          user_block;
   logic                          ahb_want;
   logic                          ahb_go;
   logic                          dma_win;
   logic                          dma_any;
   logic [ID_W-1:0]               dma_sel;

   assign accept  = HSEL_I && HTRANS_I[1] && HREADY_I;
   assign addr_hit = (HADDR_I[31:AW] == rwgda_pkg::RAM_BASE[31:AW]) &&
                     in_ram(HADDR_I[AW-1:0]);
   assign user_block = HWRITE_I && !HPROT_I[rwgda_pkg::HPROT_PRIV_BIT] &&
                       blk_prot(prot_map_reg, HADDR_I[AW-1:0]);

   // wait states counted before the RAM slot
   assign ahb_want = (ahb_state_reg == rwgda_pkg::AHB_DATA) &&
                     (wait_cnt_reg == 2'h0);
   // a processor that lost once wins next
   assign dma_win  = dma_any && !(ahb_want && ahb_starved_reg);
   assign ahb_go   = ahb_want && !dma_win;

   always_comb begin
      ahb_state_next = ahb_state_reg;
      case (ahb_state_reg)
         rwgda_pkg::AHB_IDLE: ahb_state_next = rwgda_pkg::AHB_IDLE;
         rwgda_pkg::AHB_DATA: begin
            if (ahb_go) begin
               ahb_state_next = rwgda_pkg::AHB_IDLE;
            end
         end
         // second error cycle follows the first
         rwgda_pkg::AHB_ERR1: ahb_state_next = rwgda_pkg::AHB_ERR2;
         rwgda_pkg::AHB_ERR2: ahb_state_next = rwgda_pkg::AHB_IDLE;
         default: ahb_state_next = rwgda_pkg::AHB_IDLE;
      endcase
      if (accept) begin
         if (!addr_hit || user_block) begin
            ahb_state_next = rwgda_pkg::AHB_ERR1;
         end else begin
            ahb_state_next = rwgda_pkg::AHB_DATA;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         ahb_state_reg <= rwgda_pkg::AHB_IDLE;
      end else begin
         ahb_state_reg <= ahb_state_next;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         dp_write_reg <= 1'b0;
         dp_addr_reg  <= '0;
         dp_mask_reg  <= 4'h0;
         wait_cnt_reg <= 2'h0;
      end else if (accept) begin
         dp_write_reg <= HWRITE_I;
         dp_addr_reg  <= HADDR_I[AW-1:0];
         dp_mask_reg  <= lane_mask(HSIZE_I, HADDR_I[1:0]);
         wait_cnt_reg <= HIGH_CLK_MODE_I ? rwgda_pkg::HIGH_WAIT_STATES
                                         : 2'h0;
      end else if (ahb_state_reg == rwgda_pkg::AHB_DATA &&
                   wait_cnt_reg != 2'h0) begin
         wait_cnt_reg <= wait_cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         ahb_starved_reg <= 1'b0;
      end else begin
         ahb_starved_reg <= ahb_want && dma_win;
      end
   end

   always_comb begin
      case (ahb_state_reg)
         rwgda_pkg::AHB_DATA: HREADYOUT_O = ahb_go;
         rwgda_pkg::AHB_ERR1: HREADYOUT_O = 1'b0;
         default:             HREADYOUT_O = 1'b1;
      endcase
   end
   assign HRESP_O = (ahb_state_reg == rwgda_pkg::AHB_ERR1) ||
                    (ahb_state_reg == rwgda_pkg::AHB_ERR2);
   // full 32-bit word from the array
   assign HRDATA_O = mem[dp_addr_reg[AW-1:2]];

   // ------------------------------------------------------------------
   // DMA arbiter and RAM port
   // ------------------------------------------------------------------
   logic [AW-1:0]  dma_addr;
   logic [31:0]    dma_wdata;
   logic           dma_is_wr;
   logic           dma_fault;

   always_comb begin
      dma_any = 1'b0;
      dma_sel = '0;
      for (int i = NUM_DMA - 1; i >= 0; i--) begin
         if (DMA_REQ_I[i]) begin
            dma_any = 1'b1;
            dma_sel = ID_W'(i);
         end
      end
   end

   assign dma_addr  = DMA_ADDR_I[dma_sel*AW +: AW];
   assign dma_wdata = DMA_WDATA_I[dma_sel*32 +: 32];
   // even channels receive, odd channels transmit
   assign dma_is_wr = !dma_sel[0];
   // map applied to DMA only when enabled
   assign dma_fault = dma_win && dma_is_wr && dma_prot_en_reg &&
                      blk_prot(prot_map_reg, dma_addr);

   // simultaneous requests, one grant per cycle
   always_comb begin
      DMA_GNT_O = '0;
      if (dma_win) begin
         DMA_GNT_O[dma_sel] = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         DMA_RVALID_O <= '0;
         DMA_RDATA_O  <= 32'h0000_0000;
      end else begin
         DMA_RVALID_O <= '0;
         if (dma_win && !dma_is_wr) begin
            DMA_RVALID_O[dma_sel] <= 1'b1;
            DMA_RDATA_O <= in_ram(dma_addr) ? mem[dma_addr[AW-1:2]]
                                            : 32'h0000_0000;
         end
      end
   end

   // DMA writes reach the array on their own path
   // rejected AHB writes never reach the array
   always_ff @(posedge CORE_CLK_I) begin
      if (dma_win && dma_is_wr && !dma_fault && in_ram(dma_addr)) begin
         mem[dma_addr[AW-1:2]] <= dma_wdata;
      end else if (ahb_go && dp_write_reg) begin
         for (int b = 0; b < 4; b++) begin
            if (dp_mask_reg[b]) begin
               mem[dp_addr_reg[AW-1:2]][b*8 +: 8] <= HWDATA_I[b*8 +: 8];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // register port
   // ------------------------------------------------------------------
   logic       reg_hit;
   logic [7:0] reg_ofs;
   logic       map_sel;
   logic [5:0] map_idx;
   logic       bus_fault_evt;

   // word decode inside the peripheral window
   assign reg_hit = REG_ADDR_I[31:8] ==
                    rwgda_pkg::PERIPH_BASE[31:8] +
                    rwgda_pkg::GUARD_OFFSET[31:8];
   assign reg_ofs = {REG_ADDR_I[7:2], 2'h0};
   assign map_idx = REG_ADDR_I[7:2];
   assign map_sel = reg_hit && (32'(map_idx) < 32'(MAP_REGS));
   assign bus_fault_evt = accept && addr_hit && user_block;

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         prot_map_reg <= '0;
      end else if (REG_WR_I && map_sel) begin
         prot_map_reg[map_idx*32 +: 32] <= REG_WDATA_I;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         dma_prot_en_reg <= rwgda_pkg::CFG_DMA_EN_RST;
         mask_reg        <= rwgda_pkg::MASK_RST;
      end else if (REG_WR_I && reg_hit) begin
         if (reg_ofs == rwgda_pkg::CFG_OFS) begin
            dma_prot_en_reg <= REG_WDATA_I[rwgda_pkg::CFG_DMA_EN_BIT];
         end
         if (reg_ofs == rwgda_pkg::MASK_OFS) begin
            mask_reg <= REG_WDATA_I[rwgda_pkg::STAT_W-1:0];
         end
      end
   end

   // sticky flags, a new event beats the clear
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         status_reg <= rwgda_pkg::STATUS_RST;
      end else begin
         if (REG_WR_I && reg_hit && reg_ofs == rwgda_pkg::STATUS_OFS) begin
            status_reg <= status_reg &
                          ~REG_WDATA_I[rwgda_pkg::STAT_W-1:0];
         end
         if (dma_fault) begin
            status_reg[rwgda_pkg::STAT_DMA_BIT] <= 1'b1;
         end
         if (bus_fault_evt) begin
            status_reg[rwgda_pkg::STAT_BUS_BIT] <= 1'b1;
         end
      end
   end

   // capture address and channel of the fault
   // first fault kept while its flag is set
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         fault_addr_reg <= '0;
         fault_id_reg   <= '0;
      end else if (dma_fault && !status_reg[rwgda_pkg::STAT_DMA_BIT]) begin
         fault_addr_reg <= dma_addr;
         fault_id_reg   <= dma_sel;
      end else if (dma_fault && REG_WR_I && reg_hit &&
                   reg_ofs == rwgda_pkg::STATUS_OFS &&
                   REG_WDATA_I[rwgda_pkg::STAT_DMA_BIT]) begin
         // clearing and a fresh fault together: keep the fresh one
         fault_addr_reg <= dma_addr;
         fault_id_reg   <= dma_sel;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         reg_rdata_reg <= 32'h0000_0000;
      end else if (REG_RD_I) begin
         reg_rdata_reg <= 32'h0000_0000;
         if (map_sel) begin
            reg_rdata_reg <= prot_map_reg[map_idx*32 +: 32];
         end else if (reg_hit) begin
            case (reg_ofs)
               rwgda_pkg::CFG_OFS:
                  reg_rdata_reg <= {31'h0, dma_prot_en_reg};
               rwgda_pkg::STATUS_OFS:
                  reg_rdata_reg <= 32'(status_reg);
               rwgda_pkg::MASK_OFS:
                  reg_rdata_reg <= 32'(mask_reg);
               rwgda_pkg::FADDR_OFS:
                  reg_rdata_reg <= rwgda_pkg::RAM_BASE |
                                   32'(fault_addr_reg);
               rwgda_pkg::FID_OFS:
                  reg_rdata_reg <= 32'(fault_id_reg);
               default:
                  reg_rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign REG_RDATA_O = reg_rdata_reg;
   assign IRQ_O = |(status_reg & mask_reg);

endmodule

/* src/rwgda_pkg.sv */
/*
 * Shared constants for the RAM front end: address map, register offsets,
 * field positions, reset values and timing.
 * Assumes one system clock; all users refer to names as rwgda_pkg::name.
 */
package rwgda_pkg;

   // ------------------------------------------------------------------
   // address map
   // ------------------------------------------------------------------
   localparam logic [31:0] RAM_BASE     = 32'h2000_0000;
   localparam logic [31:0] PERIPH_BASE  = 32'h4000_0000;
   localparam logic [31:0] GUARD_OFFSET = 32'h0000_6000;
   localparam int          RAM_BYTES    = 12288;
   localparam int          BLOCK_BYTES  = 32;
   localparam int          BYTE_ADDR_W  = 14;

   // ------------------------------------------------------------------
   // register offsets (byte offsets inside the guard window)
   // ------------------------------------------------------------------
   localparam logic [7:0] MAP_OFS    = 8'h00;
   localparam logic [7:0] CFG_OFS    = 8'h30;
   localparam logic [7:0] STATUS_OFS = 8'h34;
   localparam logic [7:0] MASK_OFS   = 8'h38;
   localparam logic [7:0] FADDR_OFS  = 8'h3C;
   localparam logic [7:0] FID_OFS    = 8'h40;

   // ------------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------------
   localparam int         CFG_DMA_EN_BIT  = 0;
   localparam int         STAT_DMA_BIT    = 0;
   localparam int         STAT_BUS_BIT    = 1;
   localparam int         STAT_W          = 2;
   localparam logic       CFG_DMA_EN_RST  = 1'b0;
   localparam logic [1:0] STATUS_RST      = 2'h0;
   localparam logic [1:0] MASK_RST        = 2'h0;
   localparam int         HPROT_PRIV_BIT  = 1;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam logic [1:0] HIGH_WAIT_STATES = 2'h2;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      AHB_IDLE,
      AHB_DATA,
      AHB_ERR1,
      AHB_ERR2
   } rwgda_ahb_state_type;

endpackage

/* testbench/rwgda_ram_guard_properties.sv */
/* Port checker for the RAM front end.
   Assumes binding onto rwgda_ram_guard, one clock domain. */
`timescale 1ns/1ps
module rwgda_ram_guard_properties #(
   parameter int RAM_BYTES = 12288,
   parameter int NUM_DMA   = 6
) (
   input wire logic               CORE_CLK_I,
   input wire logic               RST_N_I,
   input wire logic               HSEL_I,
   input wire logic [31:0]        HADDR_I,
   input wire logic [1:0]         HTRANS_I,
   input wire logic               HWRITE_I,
   input wire logic               HREADY_I,
   input wire logic               HREADYOUT_O,
   input wire logic               HRESP_O,
   input wire logic               HIGH_CLK_MODE_I,
   input wire logic [NUM_DMA-1:0] DMA_REQ_I,
   input wire logic [NUM_DMA-1:0] DMA_GNT_O,
   input wire logic [NUM_DMA-1:0] DMA_RVALID_O,
   input wire logic               REG_RD_I,
   input wire logic [31:0]        REG_RDATA_O,
   input wire logic               IRQ_O
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic take;
   logic in_ram;
   assign take   = HSEL_I & HTRANS_I[1] & HREADY_I;
   assign in_ram = (HADDR_I - rwgda_pkg::RAM_BASE) < 32'(RAM_BYTES);

   property p_err_two;
      HRESP_O && !HREADYOUT_O |=> HRESP_O && HREADYOUT_O;
   endproperty
   a_err_two: assert property (p_err_two)
      else $error("error response not two cycles");
   property p_range;
      take && !in_ram |=> HRESP_O && !HREADYOUT_O;
   endproperty
   a_range: assert property (p_range)
      else $error("outside ram not refused");
   property p_zero;
      (take && in_ram && !HWRITE_I && !HIGH_CLK_MODE_I && DMA_REQ_I == '0)
         ##1 (DMA_REQ_I == '0) |-> HREADYOUT_O;
   endproperty
   a_zero: assert property (p_zero)
      else $error("wait state in normal mode");
   property p_high;
      take && in_ram && !HWRITE_I && HIGH_CLK_MODE_I |=> !HREADYOUT_O [*2];
   endproperty
   a_high: assert property (p_high)
      else $error("fewer than two waits in high mode");
   property p_one;
      $onehot0(DMA_GNT_O);
   endproperty
   a_one: assert property (p_one)
      else $error("more than one dma grant");
   property p_top;
      DMA_REQ_I[0] && DMA_GNT_O != '0 |-> DMA_GNT_O[0];
   endproperty
   a_top: assert property (p_top)
      else $error("mac channel passed over");
   property p_sc1;
      DMA_GNT_O[3] |-> !DMA_REQ_I[2] && !DMA_REQ_I[0];
   endproperty
   a_sc1: assert property (p_sc1)
      else $error("transmit granted before receive");
   property p_rvalid;
      DMA_GNT_O[3] |=> DMA_RVALID_O[3];
   endproperty
   a_rvalid: assert property (p_rvalid)
      else $error("read grant without valid");
   property p_rhold;
      !REG_RD_I |=> $stable(REG_RDATA_O);
   endproperty
   a_rhold: assert property (p_rhold)
      else $error("register read data moved");
   c_err: cover property (HRESP_O && HREADYOUT_O);
   c_irq: cover property ($rose(IRQ_O));
   c_both: cover property (DMA_REQ_I[2] && DMA_REQ_I[3]);
endmodule

bind rwgda_ram_guard rwgda_ram_guard_properties #(
   .RAM_BYTES(RAM_BYTES), .NUM_DMA(NUM_DMA)
) i_rwgda_ram_guard_properties (
   .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I),
   .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
   .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .HIGH_CLK_MODE_I(HIGH_CLK_MODE_I), .DMA_REQ_I(DMA_REQ_I),
   .DMA_GNT_O(DMA_GNT_O), .DMA_RVALID_O(DMA_RVALID_O),
   .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .IRQ_O(IRQ_O));

/* testbench/rwgda_dma_model.sv */
/* Six peripheral dma channels: each request held until granted.
   Assumes the bench loads channels with one-cycle pulses. */
`timescale 1ns/1ps
module rwgda_dma_model (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [5:0]   load_i,
   input  wire logic [13:0]  addr_i,
   input  wire logic [31:0]  data_i,
   input  wire logic [5:0]   gnt_i,
   output logic      [5:0]   req_o,
   output logic      [83:0]  addr_o,
   output logic      [191:0] wdata_o
);
   // ------------------------------------------------------------
   // request hold
   // ------------------------------------------------------------
   // six channels, own path
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 6; i++) begin
         if (!rst_n_i) begin
            req_o[i] <= 1'b0;
         end else if (load_i[i]) begin
            req_o[i]          <= 1'b1;
            addr_o[14*i+:14]  <= addr_i;
            wdata_o[32*i+:32] <= data_i;
         end else if (gnt_i[i]) begin
            // released lines flip so stale values never pass
            req_o[i]          <= 1'b0;
            addr_o[14*i+:14]  <= ~addr_o[14*i+:14];
            wdata_o[32*i+:32] <= ~wdata_o[32*i+:32];
         end
      end
   end
endmodule

/* testbench/rwgda_ram_guard_tb_top.sv */
/* Bench for the RAM front end: AHB master, dma model, register port.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module rwgda_ram_guard_tb_top;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        hmode = 1'b0;
   logic        rwr = 1'b0;
   logic        rrd = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [3:0]  hprot = 4'h0;
   logic [5:0]  ld = 6'h0;
   logic [13:0] la = 14'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] ldat = 32'h0;
   logic [31:0] raddr = 32'h0;
   logic [31:0] rwdata = 32'h0;
   logic        hready, hresp, irq, rsp;
   logic [31:0] hrdata, drdata, rrdata, rd, dseen;
   logic [5:0]  dreq, dgnt, drv;
   logic [83:0] daddr;
   logic [191:0] dwdata;
   int          w, mismatches = 0, samples_checked = 0;

   rwgda_ram_guard i_rwgda_ram_guard (
      .CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
      .HPROT_I(hprot), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata),
      .HIGH_CLK_MODE_I(hmode), .DMA_REQ_I(dreq), .DMA_ADDR_I(daddr),
      .DMA_WDATA_I(dwdata), .DMA_GNT_O(dgnt), .DMA_RVALID_O(drv),
      .DMA_RDATA_O(drdata), .REG_ADDR_I(raddr), .REG_WDATA_I(rwdata),
      .REG_WR_I(rwr), .REG_RD_I(rrd), .REG_RDATA_O(rrdata), .IRQ_O(irq));
   rwgda_dma_model i_rwgda_dma_model (
      .clk_i(clk), .rst_n_i(rst_n), .load_i(ld), .addr_i(la),
      .data_i(ldat), .gnt_i(dgnt), .req_o(dreq), .addr_o(daddr),
      .wdata_o(dwdata));

   initial forever #4 clk = ~clk;
   always @(negedge clk) if (drv[1] === 1'b1 || drv[3] === 1'b1) dseen = drdata;

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] ofs,
                      input logic [2:0] sz, input logic [3:0] pr,
                      input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= rwgda_pkg::RAM_BASE + ofs;
      hwrite <= wr;
      hsize  <= sz;
      hprot  <= pr;
      @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      w = 0;
      @(negedge clk);
      while (!hready && w < 9) begin
         w++;
         @(negedge clk);
      end
      rd  = hrdata;
      rsp = hresp;
   endtask
   // user-mode word read
   task automatic rd_chk(input logic [31:0] ofs, input logic [31:0] exp);
      ahb(1'b0, ofs, 3'h2, 4'h1, 32'h0);
      chk(rd, exp);
   endtask
   task automatic reg_wr(input logic [7:0] ofs, input logic [31:0] d);
      @(posedge clk);
      raddr  <= rwgda_pkg::PERIPH_BASE + rwgda_pkg::GUARD_OFFSET + ofs;
      rwdata <= d;
      rwr    <= 1'b1;
      @(posedge clk);
      rwr    <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] ofs, input logic [31:0] exp);
      @(posedge clk);
      raddr <= rwgda_pkg::PERIPH_BASE + rwgda_pkg::GUARD_OFFSET + ofs;
      rrd   <= 1'b1;
      @(posedge clk);
      rrd   <= 1'b0;
      @(negedge clk);
      chk(rrdata, exp);
   endtask
   task automatic dma(input logic [5:0] m, input logic [13:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      ld   <= m;
      la   <= a;
      ldat <= d;
      @(posedge clk);
      ld   <= 6'h0;
      @(negedge clk);
      for (int n = 0; n < 20 && |((dreq | drv) & m); n++) @(negedge clk);
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   // the sequence needs well under 2000 cycles
   initial begin
      #100000;
      mismatches++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      reg_rd(rwgda_pkg::STATUS_OFS, 32'h0);
      reg_rd(rwgda_pkg::CFG_OFS, 32'h0);
      ahb(1'b1, 32'h20, 3'h2, 4'h3, 32'hA5A5_0F0F);
      rd_chk(32'h20, 32'hA5A5_0F0F);
      ahb(1'b1, 32'h21, 3'h0, 4'h1, 32'h0000_3C00);
      rd_chk(32'h20, 32'hA5A5_3C0F);
      chk(w, 32'h0);
      @(posedge clk);
      hmode <= 1'b1;
      rd_chk(32'h20, 32'hA5A5_3C0F);
      chk(w, 32'h2);
      @(posedge clk);
      hmode <= 1'b0;
      reg_wr(rwgda_pkg::MAP_OFS, 32'h0000_0002);
      ahb(1'b1, 32'h20, 3'h2, 4'h1, 32'hFFFF_FFFF);
      chk(rsp, 32'h1);
      rd_chk(32'h20, 32'hA5A5_3C0F);
      ahb(1'b1, 32'h1C, 3'h2, 4'h1, 32'h0BAD_0001);
      chk(rsp, 32'h0);
      ahb(1'b1, 32'h20, 3'h2, 4'h3, 32'h1234_5678);
      chk(rsp, 32'h0);
      rd_chk(32'h20, 32'h1234_5678);
      reg_rd(rwgda_pkg::STATUS_OFS, 32'h2);
      reg_wr(rwgda_pkg::STATUS_OFS, 32'h2);
      reg_rd(rwgda_pkg::STATUS_OFS, 32'h0);
      ahb(1'b0, 32'h3000, 3'h2, 4'h3, 32'h0);
      chk(rsp, 32'h1);
      reg_wr(rwgda_pkg::CFG_OFS, 32'h1);
      reg_wr(rwgda_pkg::MASK_OFS, 32'h1);
      dma(6'h02, 14'h0020, 32'h0);
      chk(dseen, 32'h1234_5678);
      reg_rd(rwgda_pkg::STATUS_OFS, 32'h0);
      dma(6'h01, 14'h0020, 32'hDEAD_BEEF);
      chk(irq, 32'h1);
      dma(6'h04, 14'h0028, 32'hDEAD_BEEF);
      reg_rd(rwgda_pkg::FADDR_OFS, 32'h2000_0020);
      reg_rd(rwgda_pkg::FID_OFS, 32'h0);
      rd_chk(32'h20, 32'h1234_5678);
      reg_wr(rwgda_pkg::MASK_OFS, 32'h0);
      @(negedge clk);
      chk(irq, 32'h0);
      reg_wr(rwgda_pkg::STATUS_OFS, 32'h1);
      dma(6'h10, 14'h0030, 32'h0);
      reg_rd(rwgda_pkg::FID_OFS, 32'h4);
      reg_rd(rwgda_pkg::FADDR_OFS, 32'h2000_0030);
      reg_wr(rwgda_pkg::STATUS_OFS, 32'h1);
      reg_wr(rwgda_pkg::CFG_OFS, 32'h0);
      dma(6'h01, 14'h002C, 32'h0000_0055);
      rd_chk(32'h2C, 32'h0000_0055);
      reg_rd(rwgda_pkg::STATUS_OFS, 32'h0);
      dma(6'h0D, 14'h0100, 32'h7777_0001);
      chk(dseen, 32'h7777_0001);
      rd_chk(32'h100, 32'h7777_0001);
      reg_rd(8'h80, 32'h0);
      complete_run();
   end
endmodule
